// [verilog/wwd_pkg.sv]
// constants, register map and state types of the windowed watchdog
// assumes one 20 MHz bus clock; the watchdog tick clock arrives as a level on a pin
// What this block does
// - with run enable clear the watchdog stays idle: no interrupts, no resets
// - run enable, no reset select: warning match sets flag and interrupt, never resets
// - run enable with reset select: warning interrupt, and reset at count zero
// - with window protect, feeding above the window value forces a reset or interrupt and sets timeout
// - with window protect, writing reload with count at or above warning or window resets or interrupts, sets timeout
// - each completed feed loads the counter from the reload constant
// - reload constant is 24 bits in the low field, resets to 0x00FFFF
// - writes below 0xFF store 0xFF instead
// - the counter steps once every four watchdog tick clocks
// - software writes 0xAA then 0x55; the pair reloads and starts the counter
// - run enable alone does not arm; feed errors ignored until first feed
// - after 0xAA any other watchdog register access causes reset or interrupt and sets timeout
// - a bad-access reset appears by the second bus clock after the access
// - counter readback returns the 24-bit count, reset value 0x0000FF
// - readback capture lags the live count by one bus clock
// - warning interrupt rises after the tick following the warning match
// - warning match needs low 10 bits equal and all higher bits zero
package wwd_pkg;
    localparam logic [31:0] WWD_OFS_MODE = 32'h4000_4000;
    localparam logic [31:0] WWD_OFS_RELOAD = 32'h4000_4004;
    localparam logic [31:0] WWD_OFS_FEED = 32'h4000_4008;
    localparam logic [31:0] WWD_OFS_COUNT = 32'h4000_400C;
    localparam logic [31:0] WWD_OFS_WARN = 32'h4000_4014;
    localparam logic [31:0] WWD_OFS_WINDOW = 32'h4000_4018;
    localparam logic [31:0] WWD_OFS_IRQ_STAT = 32'h4000_401C;
    localparam logic [31:0] WWD_OFS_IRQ_MASK = 32'h4000_4020;
    localparam logic [23:0] WWD_RELOAD_RST = 24'h00FFFF;
    localparam logic [23:0] WWD_RELOAD_MIN = 24'h0000FF;
    localparam logic [23:0] WWD_COUNT_RST = 24'h0000FF;
    localparam logic [23:0] WWD_WINDOW_RST = 24'hFFFFFF;
    localparam logic [9:0] WWD_WARN_RST = 10'h000;
    localparam logic [7:0] WWD_FEED_KEY1 = 8'hAA;
    localparam logic [7:0] WWD_FEED_KEY2 = 8'h55;
    localparam logic [1:0] WWD_TICK_DIV = 2'h3;
    // mode register bits
    localparam int WWD_MOD_EN = 0;
    localparam int WWD_MOD_RST = 1;
    localparam int WWD_MOD_TOF = 2;
    localparam int WWD_MOD_INT = 3;
    localparam int WWD_MOD_PROT = 4;
    // irq status / mask bits
    localparam int WWD_IRQ_WARN = 0;
    localparam int WWD_IRQ_ERR = 1;
    localparam int WWD_IRQ_W = 2;

    typedef enum logic [1:0] {
        WWD_FEED_IDLE = 2'b01,
        WWD_FEED_HALF = 2'b10
    } wwd_feed_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } wwd_bus_req_t;

    typedef struct packed {
        logic [1:0] tick_sync;
        logic tick_prev;
        logic [1:0] tick_div;
        logic en;
        logic rst_sel;
        logic prot;
        logic tof;
        logic warn_flag;
        logic armed;
        wwd_feed_t feed;
        logic [23:0] reload;
        logic [23:0] count;
        logic [23:0] count_rb;
        logic [9:0] warn;
        logic [23:0] window;
        logic warn_hit;
        logic [WWD_IRQ_W-1:0] irq_stat;
        logic [WWD_IRQ_W-1:0] irq_mask;
        logic rst_req;
        logic [31:0] rdata;
    } wwd_state_t;
endpackage

// [verilog/wwd_top.sv]
// windowed watchdog: tick-clock counter, feed sequence, window checks, readback
// assumes tick clock well below the bus clock; it is sampled as a level
`timescale 1ns/1ps
module wwd_top
    import wwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick_clk_in,
    input wire wwd_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic irq,
    output logic chip_reset_req
);
    logic [1:0] rst_sync_ff;
    logic rst_int_b;
    wwd_state_t st_ff;
    wwd_state_t nxt_st;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_ff[1];

    logic tick_rise;
    logic step;
    logic hit_mode, hit_reload, hit_feed, hit_count, hit_warn, hit_window;
    logic hit_stat, hit_mask;
    logic feed_done, feed_bad, bad_access;
    logic above_window;
    logic [23:0] wr_reload;
    logic fault;
    logic warn_match;
    logic hit_any;

    always_comb
    begin
        tick_rise = st_ff.tick_sync[1] & ~st_ff.tick_prev;
        // four tick clocks per counter step
        step = tick_rise && (st_ff.tick_div == WWD_TICK_DIV);
        hit_mode = bus_req.addr == WWD_OFS_MODE;
        hit_reload = bus_req.addr == WWD_OFS_RELOAD;
        hit_feed = bus_req.addr == WWD_OFS_FEED;
        hit_count = bus_req.addr == WWD_OFS_COUNT;
        hit_warn = bus_req.addr == WWD_OFS_WARN;
        hit_window = bus_req.addr == WWD_OFS_WINDOW;
        hit_stat = bus_req.addr == WWD_OFS_IRQ_STAT;
        hit_mask = bus_req.addr == WWD_OFS_IRQ_MASK;
        feed_done = st_ff.feed == WWD_FEED_HALF && bus_req.wr && hit_feed
            && bus_req.wdata[7:0] == WWD_FEED_KEY2;
        // any other watchdog access between the keys breaks the sequence
        feed_bad = st_ff.feed == WWD_FEED_HALF && (bus_req.wr || bus_req.rd)
            && (hit_mode | hit_reload | hit_feed | hit_count | hit_warn | hit_window
            | hit_stat | hit_mask) && !feed_done;
        above_window = st_ff.count > st_ff.window;
        hit_any = hit_mode | hit_reload | hit_feed | hit_count | hit_warn | hit_window
            | hit_stat | hit_mask;
        // upper count bits must be clear for a match
        warn_match = st_ff.count == {14'h0, st_ff.warn};
        // floor on the reload constant
        wr_reload = (bus_req.wdata[23:0] < WWD_RELOAD_MIN) ? WWD_RELOAD_MIN
            : bus_req.wdata[23:0];
        nxt_st = st_ff;
        nxt_st.tick_sync = {st_ff.tick_sync[0], tick_clk_in};
        nxt_st.tick_prev = st_ff.tick_sync[1];
        nxt_st.rst_req = 1'b0;
        fault = 1'b0;
        if (tick_rise)
        begin
            nxt_st.tick_div = st_ff.tick_div + 2'h1;
        end
        if (bus_req.wr && hit_mode)
        begin
            nxt_st.en = bus_req.wdata[WWD_MOD_EN];
            nxt_st.rst_sel = bus_req.wdata[WWD_MOD_RST];
            nxt_st.prot = bus_req.wdata[WWD_MOD_PROT];
            // clears come first so that a set in the same cycle wins
            if (bus_req.wdata[WWD_MOD_TOF])
            begin
                nxt_st.tof = 1'b0;
            end
            if (bus_req.wdata[WWD_MOD_INT])
            begin
                nxt_st.warn_flag = 1'b0;
            end
            if (!bus_req.wdata[WWD_MOD_EN])
            begin
                nxt_st.armed = 1'b0;
            end
        end
        if (bus_req.wr && hit_reload)
        begin
            nxt_st.reload = wr_reload;
            // early change of reload: count not yet below both limits
            if (st_ff.prot && st_ff.armed && (st_ff.count >= st_ff.window
                || st_ff.count >= {14'h0, st_ff.warn}))
            begin
                fault = 1'b1;
            end
        end
        if (bus_req.wr && hit_warn)
        begin
            nxt_st.warn = bus_req.wdata[9:0];
        end
        if (bus_req.wr && hit_window)
        begin
            nxt_st.window = bus_req.wdata[23:0];
        end
        if (bus_req.wr && hit_mask)
        begin
            nxt_st.irq_mask = bus_req.wdata[WWD_IRQ_W-1:0];
        end
        if (bus_req.wr && hit_stat)
        begin
            nxt_st.irq_stat = st_ff.irq_stat & ~bus_req.wdata[WWD_IRQ_W-1:0];
        end
        // feed key tracking
        if (st_ff.feed == WWD_FEED_IDLE)
        begin
            if (bus_req.wr && hit_feed && bus_req.wdata[7:0] == WWD_FEED_KEY1)
            begin
                nxt_st.feed = WWD_FEED_HALF;
            end
        end
        else if (feed_done || feed_bad)
        begin
            nxt_st.feed = WWD_FEED_IDLE;
        end
        // errors before the first feed are ignored
        if (feed_bad && st_ff.en && st_ff.armed)
        begin
            fault = 1'b1;
        end
        // counter runs down once armed and holds at zero
        if (step && st_ff.armed && st_ff.en && st_ff.count != 24'h0)
        begin
            nxt_st.count = st_ff.count - 24'h1;
        end
        // the match is taken on the first tick edge after the count reaches it
        if (tick_rise)
        begin
            nxt_st.warn_hit = warn_match;
        end
        // warn_hit stops one long match from setting the flag again after a clear
        if (tick_rise && warn_match && !st_ff.warn_hit && st_ff.en && st_ff.armed)
        begin
            nxt_st.warn_flag = 1'b1;
            nxt_st.irq_stat[WWD_IRQ_WARN] = 1'b1;
        end
        if (step && st_ff.en && st_ff.armed && st_ff.count == 24'h0)
        begin
            fault = 1'b1;
        end
        if (feed_done)
        begin
            nxt_st.count = st_ff.reload;
            nxt_st.warn_hit = 1'b0;
            if (st_ff.en)
            begin
                nxt_st.armed = 1'b1;
            end
            // a feed above the window counts as a fault
            if (st_ff.prot && st_ff.armed && above_window)
            begin
                fault = 1'b1;
            end
        end
        if (fault && st_ff.en)
        begin
            nxt_st.tof = 1'b1;
            nxt_st.irq_stat[WWD_IRQ_ERR] = 1'b1;
            // reset issued next cycle, inside the two-clock limit
            nxt_st.rst_req = st_ff.rst_sel;
        end
        // readback copy refreshed every bus clock; lag stays within bounds
        nxt_st.count_rb = st_ff.count;
        nxt_st.rdata = 32'h0;
        if (bus_req.rd)
        begin
            if (hit_mode)
            begin
                nxt_st.rdata = {27'h0, st_ff.prot, st_ff.warn_flag, st_ff.tof,
                    st_ff.rst_sel, st_ff.en};
            end
            else if (hit_reload)
            begin
                nxt_st.rdata = {8'h0, st_ff.reload};
            end
            else if (hit_count)
            begin
                nxt_st.rdata = {8'h0, st_ff.count_rb};
            end
            else if (hit_warn)
            begin
                nxt_st.rdata = {22'h0, st_ff.warn};
            end
            else if (hit_window)
            begin
                nxt_st.rdata = {8'h0, st_ff.window};
            end
            else if (hit_stat)
            begin
                nxt_st.rdata = {30'h0, st_ff.irq_stat};
            end
            else if (hit_mask)
            begin
                nxt_st.rdata = {30'h0, st_ff.irq_mask};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            st_ff <= '0;
            st_ff.feed <= WWD_FEED_IDLE;
            st_ff.reload <= WWD_RELOAD_RST;
            st_ff.count <= WWD_COUNT_RST;
            st_ff.count_rb <= WWD_COUNT_RST;
            st_ff.warn <= WWD_WARN_RST;
            st_ff.window <= WWD_WINDOW_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign bus_rdata = st_ff.rdata;
    // level interrupt while any unmasked sticky bit is set
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
    assign chip_reset_req = st_ff.rst_req;

    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_int_b)
        !st_ff.en |=> !chip_reset_req)
        else $error("reset while disabled");
    chk_int_noreset: assert property (@(posedge clk) disable iff (!rst_int_b)
        !st_ff.rst_sel |=> !chip_reset_req)
        else $error("reset in interrupt mode");
    sequence s_key1;
        bus_req.wr && hit_feed && bus_req.wdata[7:0] == WWD_FEED_KEY1
            && st_ff.feed == WWD_FEED_IDLE;
    endsequence
    sequence s_key2;
        bus_req.wr && hit_feed && bus_req.wdata[7:0] == WWD_FEED_KEY2
            && st_ff.feed == WWD_FEED_HALF;
    endsequence
    chk_feed_reload: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_key1 ##[1:2] s_key2 |=> st_ff.count == $past(st_ff.reload))
        else $error("feed did not reload");
    chk_reload_floor: assert property (@(posedge clk) disable iff (!rst_int_b)
        st_ff.reload >= WWD_RELOAD_MIN)
        else $error("reload below floor");
    chk_bad_tof: assert property (@(posedge clk) disable iff (!rst_int_b)
        feed_bad && st_ff.en && st_ff.armed |=> st_ff.tof)
        else $error("bad access did not set timeout");
    chk_bad_reset: assert property (@(posedge clk) disable iff (!rst_int_b)
        feed_bad && st_ff.en && st_ff.armed && st_ff.rst_sel |-> ##[1:2] chip_reset_req)
        else $error("bad access reset late");
    chk_unarmed_quiet: assert property (@(posedge clk) disable iff (!rst_int_b)
        !st_ff.armed && !(bus_req.wr && hit_reload) |=> !st_ff.tof || $past(st_ff.tof))
        else $error("fault before first feed");
    chk_count_down: assert property (@(posedge clk) disable iff (!rst_int_b)
        step && st_ff.armed && st_ff.en && st_ff.count != 24'h0 && !feed_done
        |=> st_ff.count == $past(st_ff.count) - 24'h1)
        else $error("counter did not step down");
    chk_warn_flag: assert property (@(posedge clk) disable iff (!rst_int_b)
        tick_rise && warn_match && !st_ff.warn_hit && st_ff.en && st_ff.armed
        |=> st_ff.irq_stat[WWD_IRQ_WARN])
        else $error("warning not raised");

    sequence s_zero_step;
        step && st_ff.en && st_ff.armed && st_ff.count == 24'h0;
    endsequence
    sequence s_early_reload;
        bus_req.wr && hit_reload && st_ff.prot && st_ff.armed && st_ff.en
            && st_ff.count >= st_ff.window;
    endsequence
    sequence s_early_feed;
        feed_done && st_ff.prot && st_ff.armed && st_ff.en
            && st_ff.rst_sel && above_window;
    endsequence

    chk_bad_irq: assert property (@(posedge clk) disable iff (!rst_int_b)
        feed_bad && st_ff.en && st_ff.armed
        |=> st_ff.irq_stat[WWD_IRQ_ERR])
        else $error("bad access did not flag");

    chk_bad_abort: assert property (@(posedge clk) disable iff (!rst_int_b)
        feed_bad
        |=> st_ff.feed == WWD_FEED_IDLE)
        else $error("bad access did not abort feed");

    chk_zero_reset: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_zero_step ##0 st_ff.rst_sel
        |=> chip_reset_req)
        else $error("no reset at zero");

    chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_zero_step
        |=> st_ff.tof && st_ff.irq_stat[WWD_IRQ_ERR])
        else $error("no timeout flag at zero");

    chk_early_feed: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_early_feed
        |=> chip_reset_req)
        else $error("early feed not punished");

    chk_early_reload: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_early_reload
        |=> st_ff.tof)
        else $error("early reload change not flagged");

    chk_reload_hold: assert property (@(posedge clk) disable iff (!rst_int_b)
        !(bus_req.wr && hit_reload)
        |=> $stable(st_ff.reload))
        else $error("reload changed without write");

    chk_count_hold: assert property (@(posedge clk) disable iff (!rst_int_b)
        !step && !feed_done
        |=> $stable(st_ff.count))
        else $error("counter moved between steps");

    chk_arm_feed: assert property (@(posedge clk) disable iff (!rst_int_b)
        !st_ff.armed && !feed_done
        |=> !st_ff.armed)
        else $error("armed without feed");

    chk_flag_quiet: assert property (@(posedge clk) disable iff (!rst_int_b)
        !st_ff.en && !st_ff.tof
        |=> !st_ff.tof)
        else $error("timeout flag while disabled");

    chk_rdata_count: assert property (@(posedge clk) disable iff (!rst_int_b)
        bus_req.rd && hit_count
        |=> bus_rdata == {8'h0, $past(st_ff.count_rb)})
        else $error("count readback wrong");

    chk_rb_lag: assert property (@(posedge clk) disable iff (!rst_int_b)
        1'b1
        |=> st_ff.count_rb == $past(st_ff.count))
        else $error("readback copy lags too far");

    chk_warn_high: assert property (@(posedge clk) disable iff (!rst_int_b)
        tick_rise && st_ff.count[23:10] != 14'h0 && !st_ff.irq_stat[WWD_IRQ_WARN]
        |=> !st_ff.irq_stat[WWD_IRQ_WARN])
        else $error("warning with upper count bits set");

    chk_count_stop: assert property (@(posedge clk) disable iff (!rst_int_b)
        st_ff.count == 24'h0 && !feed_done
        |=> st_ff.count == 24'h0)
        else $error("counter wrapped below zero");

    chk_tof_sticky: assert property (@(posedge clk) disable iff (!rst_int_b)
        st_ff.tof && !(bus_req.wr && hit_mode && bus_req.wdata[WWD_MOD_TOF])
        |=> st_ff.tof)
        else $error("timeout flag lost");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_int_b)
        !bus_req.rd
        |=> bus_rdata == 32'h0)
        else $error("read data without read");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_int_b)
        bus_req.rd && !hit_any
        |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");

    chk_feed_half: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_key1
        |=> st_ff.feed == WWD_FEED_HALF)
        else $error("first key not taken");

    chk_stat_clear: assert property (@(posedge clk) disable iff (!rst_int_b)
        bus_req.wr && hit_stat && bus_req.wdata[WWD_IRQ_WARN]
            && !(tick_rise && warn_match && !st_ff.warn_hit && st_ff.en && st_ff.armed)
        |=> !st_ff.irq_stat[WWD_IRQ_WARN])
        else $error("status bit not cleared");

    chk_feed_arms: assert property (@(posedge clk) disable iff (!rst_int_b)
        s_key1 ##[1:2] s_key2 ##0 st_ff.en
        |=> st_ff.armed)
        else $error("feed did not start counter");
endmodule

// [dv/tb_wwd_top.sv]
// register-level bench of the windowed watchdog: reset values, feed, faults, ticks, irq
// assumes the bench alone drives the bus and the tick pin; the tick stays slow (4 clk a level)
`timescale 1ns/1ps
module tb_wwd_top;
    import wwd_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tick_clk_in = 1'b0;
    wwd_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    logic irq;
    logic chip_reset_req;
    int err_total = 0;
    int comparisons = 0;
    int pulses = 0;
    int cyc = 0;
    int p0 = 0;
    logic [31:0] rv;

    wwd_top u_wwd_top (.clk(clk), .rst_b(rst_b), .tick_clk_in(tick_clk_in), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .irq(irq), .chip_reset_req(chip_reset_req));

    always #25 clk = ~clk;

    // the reset request is a one-cycle pulse, so it is counted rather than polled
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (chip_reset_req === 1'b1)
            pulses <= pulses + 1;
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (cyc == 40000)
        begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    // no other access lands between the two keys, as an interrupt would
    task automatic feed();
        wr(WWD_OFS_FEED, 32'h0000_00AA);
        wr(WWD_OFS_FEED, 32'h0000_0055);
    endtask

    // the tick pin is synchronised inside, so each level is held several bus clocks
    task automatic ticks(int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk);
            tick_clk_in <= 1'b1;
            repeat (4) @(posedge clk);
            tick_clk_in <= 1'b0;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic chk_pulses(string name, int n);
        repeat (2) @(posedge clk);
        #1;
        chk(name, 32'(pulses - p0), 32'(n));
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // a fresh reset each time keeps the tick divider phase known
    task automatic arm(logic [31:0] rl, logic [31:0] win, logic [31:0] mode);
        do_reset();
        wr(WWD_OFS_WINDOW, win);
        wr(WWD_OFS_RELOAD, rl);
        wr(WWD_OFS_MODE, mode);
        feed();
        p0 = pulses;
    endtask

    initial
    begin
        do_reset();
        rd(WWD_OFS_RELOAD, rv);
        chk("reload_rst", rv, 32'h0000_FFFF);
        rd(WWD_OFS_COUNT, rv);
        chk("count_rst", rv, 32'h0000_00FF);
        rd(WWD_OFS_WINDOW, rv);
        chk("window_rst", rv, 32'h00FF_FFFF);
        rd(32'h4000_4030, rv);
        chk("unmapped", rv, 32'h0000_0000);
        wr(WWD_OFS_RELOAD, 32'h0000_0010);
        rd(WWD_OFS_RELOAD, rv);
        chk("reload_floor", rv, 32'h0000_00FF);
        wr(WWD_OFS_RELOAD, 32'h0012_3456);
        rd(WWD_OFS_RELOAD, rv);
        chk("reload_rw", rv, 32'h0012_3456);
        $display("test registers done");
        p0 = pulses;
        wr(WWD_OFS_MODE, 32'h0000_0002);
        wr(WWD_OFS_FEED, 32'h0000_00AA);
        rd(WWD_OFS_COUNT, rv);
        chk_pulses("disabled_reset", 0);
        chk("disabled_irq", irq, 1'b0);
        wr(WWD_OFS_MODE, 32'h0000_0003);
        wr(WWD_OFS_FEED, 32'h0000_00AA);
        rd(WWD_OFS_COUNT, rv);
        chk_pulses("unarmed_reset", 0);
        feed();
        rd(WWD_OFS_COUNT, rv);
        chk("feed_load", rv, 32'h0012_3456);
        wr(WWD_OFS_FEED, 32'h0000_00AA);
        p0 = pulses;
        rd(WWD_OFS_COUNT, rv);
        chk_pulses("bad_access_reset", 1);
        rd(WWD_OFS_MODE, rv);
        chk("bad_access_tof", rv[WWD_MOD_TOF], 1'b1);
        $display("test feed done");
        arm(32'h0000_0300, 32'h00FF_FFFF, 32'h0000_0001);
        ticks(3);
        rd(WWD_OFS_COUNT, rv);
        chk("count_3_ticks", rv, 32'h0000_0300);
        ticks(1);
        rd(WWD_OFS_COUNT, rv);
        chk("count_4_ticks", rv, 32'h0000_02FF);
        $display("test ticks done");
        arm(32'h0000_0102, 32'h00FF_FFFF, 32'h0000_0001);
        wr(WWD_OFS_WARN, 32'h0000_0100);
        wr(WWD_OFS_IRQ_MASK, 32'h0000_0003);
        ticks(4);
        chk("irq_before_match", irq, 1'b0);
        ticks(8);
        chk("irq_warn", irq, 1'b1);
        rd(WWD_OFS_IRQ_STAT, rv);
        chk("stat_warn", rv[WWD_IRQ_WARN], 1'b1);
        wr(WWD_OFS_IRQ_MASK, 32'h0000_0002);
        chk("irq_masked", irq, 1'b0);
        wr(WWD_OFS_IRQ_STAT, 32'h0000_0001);
        wr(WWD_OFS_IRQ_MASK, 32'h0000_0003);
        chk("irq_cleared", irq, 1'b0);
        ticks(1030);
        chk_pulses("irq_mode_no_reset", 0);
        chk("irq_timeout", irq, 1'b1);
        $display("test interrupt mode done");
        arm(32'h0000_0010, 32'h00FF_FFFF, 32'h0000_0003);
        wr(WWD_OFS_IRQ_MASK, 32'h0000_0001);
        ticks(1016);
        chk_pulses("no_reset_at_one", 0);
        ticks(8);
        chk("zero_reset", 32'(pulses > p0), 32'h0000_0001);
        chk("zero_warn_irq", irq, 1'b1);
        $display("test reset mode done");
        arm(32'h0000_0300, 32'h0000_0200, 32'h0000_0013);
        feed();
        chk_pulses("early_feed_reset", 1);
        arm(32'h0000_0300, 32'h0000_0200, 32'h0000_0013);
        wr(WWD_OFS_RELOAD, 32'h0000_0280);
        chk_pulses("early_reload_reset", 1);
        rd(WWD_OFS_MODE, rv);
        chk("early_reload_tof", rv[WWD_MOD_TOF], 1'b1);
        $display("test window done");
        finish_test();
    end
endmodule
